// file: design/pin_driver.v
// one output pin: forced data, override, polarity and ownership, registered
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
    input wire clk_i,
    input wire rst_i,
    input wire gen_i,
    input wire ovr_en_i,
    input wire ovr_val_i,
    input wire force_i,
    input wire force_val_i,
    input wire active_low_i,
    input wire owned_i,
    input wire gpio_i,
    output reg pin_o
);
    reg logical;

    always @* begin
        if (force_i) begin
            logical = force_val_i;
        end else if (ovr_en_i) begin
            logical = ovr_val_i;
        end else begin
            logical = gen_i;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 1'b0;
        end else if (owned_i) begin
            pin_o <= logical ^ active_low_i;
        end else begin
            pin_o <= gpio_i;
        end
    end
endmodule
`default_nettype wire

// file: design/pwm_trig_pin_consts.vh
// register map, field positions and reset values of the trigger and pin control block
`ifndef PWM_TRIG_PIN_CONSTS_VH
`define PWM_TRIG_PIN_CONSTS_VH

// word offsets on the bus (byte addresses)
`define OFS_TRIGGER_CONTROL 8'h00
`define OFS_OUTPUT_PIN_CONTROL 8'h04
`define OFS_MODULE_CONTROL 8'h08
`define OFS_EVENT_STATUS 8'h0C
`define OFS_EVENT_MASK 8'h10

// trigger_control fields
`define TRG_DIV_HI 15
`define TRG_DIV_LO 12
`define TRG_DUAL_BIT 7
`define TRG_START_HI 5
`define TRG_START_LO 0
`define TRG_WRITABLE 16'hF0BF
`define TRG_RESET 16'h0000

// output_pin_control fields
`define PIN_HIGH_OWN_BIT 15
`define PIN_LOW_OWN_BIT 14
`define PIN_HIGH_POL_BIT 13
`define PIN_LOW_POL_BIT 12
`define PIN_MODE_HI 11
`define PIN_MODE_LO 10
`define PIN_HIGH_OVR_BIT 9
`define PIN_LOW_OVR_BIT 8
`define PIN_OVR_VAL_HI 7
`define PIN_OVR_VAL_LO 6
`define PIN_FLT_VAL_HI 5
`define PIN_FLT_VAL_LO 4
`define PIN_CL_VAL_HI 3
`define PIN_CL_VAL_LO 2
`define PIN_SWAP_BIT 1
`define PIN_OVR_SYNC_BIT 0
`define PIN_RESET 16'h0000

// pin pair modes
`define MODE_COMPLEMENTARY 2'h0
`define MODE_REDUNDANT 2'h1
`define MODE_PUSH_PULL 2'h2
`define MODE_INDEPENDENT 2'h3

// module_control fields
`define CTL_ENABLE_BIT 0
`define CTL_FAULT_MODE_BIT 1
`define CTL_WRITABLE 16'h0003
`define CTL_RESET 16'h0000

// event status and mask layout
`define EVT_PRIMARY_BIT 0
`define EVT_FAULT_BIT 1
`define EVT_CLIMIT_BIT 2
`define EVT_WIDTH 3
`define EVT_RESET 3'h0

`endif

// file: design/pwm_trigger_pin_control.v
// trigger postscaler, pin pair mapping and event interrupts behind a wishbone slave
//
// Behaviour
// - trigger output once per divider-plus-one accepted trigger events
// - dual-trigger set merges secondary into primary; clear gives two triggers
// - after enable, wait start-delay pwm cycles before the first trigger
// - secondary trigger events raise the trigger interrupt only with dual-trigger set, merged into primary
// - trigger control bits 11..8 and 6 always read zero
// - ownership bit set gives pin to pwm, clear gives it to gpio
// - polarity bit set makes its pin active low
// - pin pair mode: complementary, redundant, push-pull, independent
// - override enable replaces generator output with override data
// - override data upper bit feeds high pin, lower bit low pin
// - normal fault mode: fault drives pins from fault data bits
// - independent mode: current limit drives high, fault drives low from fault data
// - normal fault mode: current limit drives pins from current-limit data
// - swap routes high signal to low pin and low to high
// - override sync aligns override changes to pwm cycle, else immediate
`timescale 1ns/1ps
`default_nettype none
`include "pwm_trig_pin_consts.vh"
module pwm_trigger_pin_control #(
    parameter DIV_W = 4,
    parameter DELAY_W = 6
) (
    input wire clk_i,
    input wire rst_i,
    // wishbone classic slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // time base and generator side
    input wire pwm_cycle_i,
    input wire primary_event_i,
    input wire secondary_event_i,
    input wire gen_high_i,
    input wire gen_low_i,
    input wire fault_i,
    input wire current_limit_i,
    input wire gpio_high_i,
    input wire gpio_low_i,
    // pins, triggers and interrupt
    output wire high_output_pin_o,
    output wire low_output_pin_o,
    output wire trigger_o,
    output wire secondary_trigger_o,
    output reg irq_o
);
    reg [15:0] trigger_control;
    reg [15:0] output_pin_control;
    reg [15:0] module_control;
    reg [`EVT_WIDTH-1:0] event_status;
    reg [`EVT_WIDTH-1:0] event_mask;
    reg [`EVT_WIDTH-1:0] next_status;
    reg [31:0] next_rdata;

    // override fields as used by the pins, possibly held to the pwm cycle
    reg ovr_high_en;
    reg ovr_low_en;
    reg [1:0] ovr_val;
    reg push_phase;
    reg fault_d;
    reg climit_d;

    wire bus_req;
    wire bus_write;
    wire module_enable;
    wire fault_mode_field;
    wire dual_trigger_select;
    wire [1:0] pin_pair_mode;
    wire swap;
    wire override_sync;
    wire [1:0] fault_value;
    wire [1:0] current_limit_value;
    wire [DIV_W-1:0] trigger_divider;
    wire [DELAY_W-1:0] trigger_start_delay;
    wire primary_in;
    wire secondary_in;
    wire prim_trig;
    wire sec_trig;
    wire prim_armed;

    // merge of a write word into a 16-bit register through the low two lanes
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0] sel;
        input [15:0] writable;
        reg [15:0] lanes;
        begin
            lanes = {{8{sel[1]}}, {8{sel[0]}}} & writable;
            merge16 = (old & ~lanes) | (wdata[15:0] & lanes);
        end
    endfunction

    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr[7:2] == ofs[7:2]);
        end
    endfunction

    assign bus_req = cyc_i & stb_i;
    // writes land on the edge where the master sees ack high
    assign bus_write = bus_req & we_i & ack_o;

    assign module_enable = module_control[`CTL_ENABLE_BIT];
    assign fault_mode_field = module_control[`CTL_FAULT_MODE_BIT];
    assign dual_trigger_select = trigger_control[`TRG_DUAL_BIT];
    assign trigger_divider = trigger_control[`TRG_DIV_HI:`TRG_DIV_LO];
    assign trigger_start_delay = trigger_control[`TRG_START_HI:`TRG_START_LO];
    assign pin_pair_mode = output_pin_control[`PIN_MODE_HI:`PIN_MODE_LO];
    assign swap = output_pin_control[`PIN_SWAP_BIT];
    assign override_sync = output_pin_control[`PIN_OVR_SYNC_BIT];
    assign fault_value = output_pin_control[`PIN_FLT_VAL_HI:`PIN_FLT_VAL_LO];
    assign current_limit_value = output_pin_control[`PIN_CL_VAL_HI:`PIN_CL_VAL_LO];

    // register writes
    always @(posedge clk_i) begin
        if (rst_i) begin
            trigger_control <= `TRG_RESET;
            output_pin_control <= `PIN_RESET;
            module_control <= `CTL_RESET;
            event_mask <= `EVT_RESET;
        end else if (bus_write) begin
            if (hit(adr_i, `OFS_TRIGGER_CONTROL)) begin
                // unimplemented positions are masked out of the store
                trigger_control <= merge16(trigger_control, dat_i, sel_i,
                                           `TRG_WRITABLE);
            end
            if (hit(adr_i, `OFS_OUTPUT_PIN_CONTROL)) begin
                // mode is taken as written; changing it while enabled is the
                // caller's hazard
                output_pin_control <= merge16(output_pin_control, dat_i, sel_i,
                                              16'hFFFF);
            end
            if (hit(adr_i, `OFS_MODULE_CONTROL)) begin
                module_control <= merge16(module_control, dat_i, sel_i,
                                          `CTL_WRITABLE);
            end
            if (hit(adr_i, `OFS_EVENT_MASK) && sel_i[0]) begin
                event_mask <= dat_i[`EVT_WIDTH-1:0];
            end
        end
    end

    // trigger sources: merged in dual mode, split otherwise
    assign primary_in = dual_trigger_select ?
                        (primary_event_i | secondary_event_i) :
                        primary_event_i;
    assign secondary_in = dual_trigger_select ? 1'b0 : secondary_event_i;

    trig_postscaler #(
        .DIV_W(DIV_W),
        .DELAY_W(DELAY_W)
    ) u_primary (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(module_enable),
        .pwm_cycle_i(pwm_cycle_i),
        .event_i(primary_in),
        .divider_i(trigger_divider),
        .start_delay_i(trigger_start_delay),
        .armed_o(prim_armed),
        .trig_o(prim_trig)
    );

    // the secondary path shares the start delay and divider settings
    trig_postscaler #(
        .DIV_W(DIV_W),
        .DELAY_W(DELAY_W)
    ) u_secondary (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(module_enable),
        .pwm_cycle_i(pwm_cycle_i),
        .event_i(secondary_in),
        .divider_i(trigger_divider),
        .start_delay_i(trigger_start_delay),
        .armed_o(),
        .trig_o(sec_trig)
    );

    assign trigger_o = prim_trig;
    assign secondary_trigger_o = sec_trig;

    // sticky events, set wins over a write-one clear in the same cycle
    always @* begin
        next_status = event_status;
        if (bus_write && hit(adr_i, `OFS_EVENT_STATUS) && sel_i[0]) begin
            next_status = next_status & ~dat_i[`EVT_WIDTH-1:0];
        end
        // only the primary path may raise the trigger event
        if (prim_trig) begin
            next_status[`EVT_PRIMARY_BIT] = 1'b1;
        end
        if (fault_i && !fault_d) begin
            next_status[`EVT_FAULT_BIT] = 1'b1;
        end
        if (current_limit_i && !climit_d) begin
            next_status[`EVT_CLIMIT_BIT] = 1'b1;
        end
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            event_status <= `EVT_RESET;
            fault_d <= 1'b0;
            climit_d <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            event_status <= next_status;
            fault_d <= fault_i;
            climit_d <= current_limit_i;
            irq_o <= |(next_status & event_mask);
        end
    end

    // override shadow: follows the register at once or only at a cycle start
    always @(posedge clk_i) begin
        if (rst_i) begin
            ovr_high_en <= 1'b0;
            ovr_low_en <= 1'b0;
            ovr_val <= 2'h0;
        end else if (!override_sync || pwm_cycle_i) begin
            ovr_high_en <= output_pin_control[`PIN_HIGH_OVR_BIT];
            ovr_low_en <= output_pin_control[`PIN_LOW_OVR_BIT];
            ovr_val <= output_pin_control[`PIN_OVR_VAL_HI:`PIN_OVR_VAL_LO];
        end
    end

    // push-pull alternates the active output on each pwm cycle
    always @(posedge clk_i) begin
        if (rst_i || !module_enable) begin
            push_phase <= 1'b0;
        end else if (pwm_cycle_i) begin
            push_phase <= ~push_phase;
        end
    end

    // pair mapping, swap and fault selection
    reg mode_high;
    reg mode_low;
    reg sig_high;
    reg sig_low;
    reg force_high;
    reg force_low;
    reg force_high_val;
    reg force_low_val;

    always @* begin
        case (pin_pair_mode)
            `MODE_COMPLEMENTARY: begin
                mode_high = gen_high_i;
                mode_low = ~gen_high_i;
            end
            `MODE_REDUNDANT: begin
                mode_high = gen_high_i;
                mode_low = gen_high_i;
            end
            `MODE_PUSH_PULL: begin
                mode_high = gen_high_i & ~push_phase;
                mode_low = gen_high_i & push_phase;
            end
            `MODE_INDEPENDENT: begin
                mode_high = gen_high_i;
                mode_low = gen_low_i;
            end
            default: begin
                mode_high = 1'b0;
                mode_low = 1'b0;
            end
        endcase
        if (swap) begin
            sig_high = mode_low;
            sig_low = mode_high;
        end else begin
            sig_high = mode_high;
            sig_low = mode_low;
        end
    end

    always @* begin
        if (fault_mode_field) begin
            // independent: each pin has its own cause, both from fault data
            force_high = current_limit_i;
            force_high_val = fault_value[1];
            force_low = fault_i;
            force_low_val = fault_value[0];
        end else if (fault_i) begin
            // fault outranks current limit
            force_high = 1'b1;
            force_high_val = fault_value[1];
            force_low = 1'b1;
            force_low_val = fault_value[0];
        end else begin
            force_high = current_limit_i;
            force_high_val = current_limit_value[1];
            force_low = current_limit_i;
            force_low_val = current_limit_value[0];
        end
    end

    pin_driver u_high (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .gen_i(sig_high),
        .ovr_en_i(ovr_high_en),
        .ovr_val_i(ovr_val[1]),
        .force_i(force_high),
        .force_val_i(force_high_val),
        .active_low_i(output_pin_control[`PIN_HIGH_POL_BIT]),
        .owned_i(output_pin_control[`PIN_HIGH_OWN_BIT]),
        .gpio_i(gpio_high_i),
        .pin_o(high_output_pin_o)
    );

    pin_driver u_low (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .gen_i(sig_low),
        .ovr_en_i(ovr_low_en),
        .ovr_val_i(ovr_val[0]),
        .force_i(force_low),
        .force_val_i(force_low_val),
        .active_low_i(output_pin_control[`PIN_LOW_POL_BIT]),
        .owned_i(output_pin_control[`PIN_LOW_OWN_BIT]),
        .gpio_i(gpio_low_i),
        .pin_o(low_output_pin_o)
    );

    // read mux; unmapped addresses answer with zero
    always @* begin
        next_rdata = 32'h00000000;
        if (hit(adr_i, `OFS_TRIGGER_CONTROL)) begin
            next_rdata[15:0] = trigger_control & `TRG_WRITABLE;
        end else if (hit(adr_i, `OFS_OUTPUT_PIN_CONTROL)) begin
            next_rdata[15:0] = output_pin_control;
        end else if (hit(adr_i, `OFS_MODULE_CONTROL)) begin
            next_rdata[15:0] = module_control;
            next_rdata[8] = prim_armed;
        end else if (hit(adr_i, `OFS_EVENT_STATUS)) begin
            next_rdata[`EVT_WIDTH-1:0] = event_status;
        end else if (hit(adr_i, `OFS_EVENT_MASK)) begin
            next_rdata[`EVT_WIDTH-1:0] = event_mask;
        end
    end

    // one wait state, ack for exactly one cycle per request
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h00000000;
        end else begin
            ack_o <= bus_req & ~ack_o;
            if (bus_req && !ack_o) begin
                dat_o <= next_rdata;
            end
        end
    end
endmodule
`default_nettype wire

// file: design/trig_postscaler.v
// trigger postscaler: start delay in pwm cycles, then one output per n+1 events
`timescale 1ns/1ps
`default_nettype none
module trig_postscaler #(
    parameter DIV_W = 4,
    parameter DELAY_W = 6
) (
    input wire clk_i,
    input wire rst_i,
    input wire enable_i,
    input wire pwm_cycle_i,
    input wire event_i,
    input wire [DIV_W-1:0] divider_i,
    input wire [DELAY_W-1:0] start_delay_i,
    output reg armed_o,
    output reg trig_o
);
    reg [DELAY_W-1:0] wait_cnt;
    reg [DIV_W-1:0] div_cnt;

    always @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
            // disabling clears everything so a re-enable starts fresh
            armed_o <= 1'b0;
            wait_cnt <= {DELAY_W{1'b0}};
            div_cnt <= {DIV_W{1'b0}};
            trig_o <= 1'b0;
        end else if (!armed_o) begin
            trig_o <= 1'b0;
            if (wait_cnt == start_delay_i) begin
                armed_o <= 1'b1;
                div_cnt <= {DIV_W{1'b0}};
            end else if (pwm_cycle_i) begin
                wait_cnt <= wait_cnt + {{(DELAY_W-1){1'b0}}, 1'b1};
            end
        end else if (event_i) begin
            if (div_cnt == divider_i) begin
                trig_o <= 1'b1;
                div_cnt <= {DIV_W{1'b0}};
            end else begin
                trig_o <= 1'b0;
                div_cnt <= div_cnt + {{(DIV_W-1){1'b0}}, 1'b1};
            end
        end else begin
            trig_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: verification/power_stage_model.sv
// far side: converter trigger inputs, counting each trigger pulse
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input wire logic clk_i,
    input wire logic trigger_i,
    input wire logic secondary_trigger_i,
    output var int trig_n_o,
    output var int sec_n_o
);
    int trig_cnt = 0;
    int sec_cnt = 0;

    assign trig_n_o = trig_cnt;
    assign sec_n_o = sec_cnt;

    // one count per high cycle, so back-to-back triggers are not merged
    always @(posedge clk_i) begin
        if (trigger_i === 1'h1)
            trig_cnt <= trig_cnt + 1;
        if (secondary_trigger_i === 1'h1)
            sec_cnt <= sec_cnt + 1;
    end
endmodule
`default_nettype wire

// file: verification/pwm_trig_pin_assertions.sv
// port-level assertions for the trigger and pin control block
`timescale 1ns/1ps
`default_nettype none
module pwm_trig_pin_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic primary_event_i,
    input wire logic secondary_event_i,
    input wire logic trigger_o,
    input wire logic secondary_trigger_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence wb_req;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence wb_ans;
        ack_o ##1 !ack_o;
    endsequence
    bus_answer_a: assert property (wb_req |=> wb_ans)
        else $error("request not answered with a one cycle ack");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without a request");
    read_upper_a: assert property (ack_o && !we_i |-> dat_o[31:16] == 16'h0000)
        else $error("upper read half not zero");
    trg_reserved_a: assert property (
        ack_o && !we_i && adr_i == 8'h00 |-> dat_o[11:8] == 4'h0 && !dat_o[6])
        else $error("unused trigger control bits read nonzero");
    status_width_a: assert property (ack_o && !we_i && adr_i == 8'h0C |-> dat_o[15:3] == 13'h0000)
        else $error("status read shows bits beyond its width");
    read_hold_a: assert property (!ack_o |-> $stable(dat_o))
        else $error("read data moved between answers");
    trig_cause_a: assert property (
        trigger_o |-> $past(primary_event_i || secondary_event_i))
        else $error("trigger without an event the cycle before");
    sec_cause_a: assert property (secondary_trigger_o |-> $past(secondary_event_i))
        else $error("secondary trigger without a secondary event");
endmodule
bind pwm_trigger_pin_control pwm_trig_pin_checker u_pwm_trig_pin_checker (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .primary_event_i(primary_event_i),
    .secondary_event_i(secondary_event_i), .trigger_o(trigger_o),
    .secondary_trigger_o(secondary_trigger_o));
`default_nettype wire

// file: verification/test_pwm_trigger_and_pin_control.sv
// self-checking bench for the trigger and pin control block
`timescale 1ns/1ps
`default_nettype none
`include "pwm_trig_pin_consts.vh"
module test_pwm_trigger_and_pin_control;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, pwm = 0, prim = 0, sec = 0;
    logic gh = 0, gl = 0, flt = 0, cl = 0, gph = 0, gpl = 0;
    logic [7:0] adr = 0;
    logic [31:0] wdat = 0, rdat;
    logic [15:0] lfsr = 16'h0004, cfg;
    wire [31:0] dat_o;
    wire ack_o, pin_h, pin_l, trig, strig, irq;
    int err_count = 0, check_count = 0, cycles = 0, trig_n, sec_n, base_t, base_s, n;
    int divs[4] = '{0, 1, 3, 15};

    pwm_trigger_pin_control u_pwm_trigger_pin_control (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(wdat),
        .dat_o(dat_o), .ack_o(ack_o), .pwm_cycle_i(pwm), .primary_event_i(prim),
        .secondary_event_i(sec), .gen_high_i(gh), .gen_low_i(gl), .fault_i(flt),
        .current_limit_i(cl), .gpio_high_i(gph), .gpio_low_i(gpl),
        .high_output_pin_o(pin_h), .low_output_pin_o(pin_l), .trigger_o(trig),
        .secondary_trigger_o(strig), .irq_o(irq));
    power_stage_model u_power_stage_model (.clk_i(clk_i), .trigger_i(trig),
        .secondary_trigger_i(strig), .trig_n_o(trig_n), .sec_n_o(sec_n));

    initial forever #25 clk_i = ~clk_i;

    task complete_run;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // run is far shorter than this; a stuck handshake lands here
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            complete_run();
        end
    end

    function automatic [15:0] next_rand(input [15:0] v);
        next_rand = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task check(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wb(input [7:0] a, input w, input [31:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        wdat <= d;
        // no wait-state count assumed; a missing ack ends in the bench timeout
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'h1);
        rdat = dat_o;
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask

    task ev(input p, input s, input int m);
        @(posedge clk_i);
        prim <= p;
        sec <= s;
        repeat (m) @(posedge clk_i);
        prim <= 0;
        sec <= 0;
        repeat (3) @(posedge clk_i);
    endtask

    task pwm_pulse;
        @(posedge clk_i);
        pwm <= 1;
        @(posedge clk_i);
        pwm <= 0;
    endtask

    // mode bits only ever change with the module disabled
    task restart(input [15:0] trg);
        wb(`OFS_MODULE_CONTROL, 1, 0);
        wb(`OFS_TRIGGER_CONTROL, 1, trg);
        wb(`OFS_MODULE_CONTROL, 1, 1);
        base_t = trig_n;
        base_s = sec_n;
    endtask

    // push-pull is modelled in its even phase only: no cycle pulses run here
    function automatic [1:0] pin_exp(input [15:0] c, input fm);
        logic h, l, t;
        h = gh;
        case (c[11:10])
            2'h0: l = ~gh;
            2'h1: l = gh;
            2'h2: l = 1'h0;
            default: l = gl;
        endcase
        if (c[1]) begin
            t = h;
            h = l;
            l = t;
        end
        if (c[9]) h = c[7];
        if (c[8]) l = c[6];
        if (!fm && flt) {h, l} = c[5:4];
        else if (!fm && cl) {h, l} = c[3:2];
        if (fm && cl) h = c[5];
        if (fm && flt) l = c[4];
        h = h ^ c[13];
        l = l ^ c[12];
        if (!c[15]) h = gph;
        if (!c[14]) l = gpl;
        pin_exp = {h, l};
    endfunction

    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 0;
        for (int a = 0; a < 24; a += 4) begin
            wb(a, 0, 0);
            check(rdat, 0);
        end
        for (int i = 0; i < 2; i++) begin
            lfsr = next_rand(lfsr);
            wb(`OFS_TRIGGER_CONTROL, 1, i ? lfsr : 16'hFFFF);
            wb(`OFS_TRIGGER_CONTROL, 0, 0);
            check(rdat, (i ? lfsr : 16'hFFFF) & 16'hF0BF);
            wb(`OFS_OUTPUT_PIN_CONTROL, 1, lfsr);
            wb(`OFS_OUTPUT_PIN_CONTROL, 0, 0);
            check(rdat, lfsr);
        end
        wb(8'h14, 1, 32'hFFFFFFFF);
        wb(8'h14, 0, 0);
        check(rdat, 0);
        $display("register test done");
        wb(`OFS_EVENT_MASK, 1, 1);
        foreach (divs[i]) begin
            restart(divs[i] << 12);
            ev(1, 0, 3 * (divs[i] + 1) - 1);
            check(trig_n - base_t, 2);
            check(irq, 1);
            wb(`OFS_EVENT_STATUS, 0, 0);
            check(rdat, 1);
            wb(`OFS_EVENT_STATUS, 1, 1);
            repeat (2) @(posedge clk_i);
            check(irq, 0);
            restart(divs[i] << 12);
            ev(1, 0, 1);
            check(trig_n - base_t, divs[i] == 0);
        end
        $display("divider test done");
        restart(16'h0003);
        ev(1, 0, 1);
        pwm_pulse();
        pwm_pulse();
        ev(1, 0, 1);
        check(trig_n - base_t, 0);
        pwm_pulse();
        ev(1, 0, 1);
        check(trig_n - base_t, 1);
        restart(16'h1080);
        ev(0, 1, 2);
        ev(1, 0, 2);
        check(trig_n - base_t, 2);
        check(sec_n - base_s, 0);
        restart(16'h1000);
        wb(`OFS_EVENT_STATUS, 1, 7);
        ev(0, 1, 4);
        check(sec_n - base_s, 2);
        check(trig_n - base_t, 0);
        check(irq, 0);
        wb(`OFS_EVENT_STATUS, 0, 0);
        check(rdat, 0);
        $display("trigger mode test done");
        for (int i = 0; i < 24; i++) begin
            lfsr = next_rand(lfsr);
            cfg = {lfsr[15:12], i[1:0], lfsr[9:1], 1'h0};
            lfsr = next_rand(lfsr);
            wb(`OFS_MODULE_CONTROL, 1, 0);
            wb(`OFS_OUTPUT_PIN_CONTROL, 1, cfg);
            wb(`OFS_MODULE_CONTROL, 1, {lfsr[6], 1'h1});
            @(posedge clk_i);
            {gh, gl, flt, cl, gph, gpl} <= lfsr[5:0];
            repeat (4) @(posedge clk_i);
            check({pin_h, pin_l}, pin_exp(cfg, lfsr[6]));
        end
        {gh, gl, flt, cl, gph, gpl} <= 6'h00;
        $display("pin test done");
        wb(`OFS_MODULE_CONTROL, 1, 0);
        wb(`OFS_OUTPUT_PIN_CONTROL, 1, 16'hCF00);
        wb(`OFS_MODULE_CONTROL, 1, 1);
        wb(`OFS_OUTPUT_PIN_CONTROL, 1, 16'hCFC1);
        repeat (4) @(posedge clk_i);
        check({pin_h, pin_l}, 0);
        pwm_pulse();
        repeat (3) @(posedge clk_i);
        check({pin_h, pin_l}, 3);
        // push-pull odd and even phases, advanced by cycle pulses
        wb(`OFS_MODULE_CONTROL, 1, 0);
        wb(`OFS_OUTPUT_PIN_CONTROL, 1, 16'hC800);
        wb(`OFS_MODULE_CONTROL, 1, 1);
        gh <= 1'h1;
        pwm_pulse();
        repeat (3) @(posedge clk_i);
        check({pin_h, pin_l}, 1);
        pwm_pulse();
        repeat (3) @(posedge clk_i);
        check({pin_h, pin_l}, 2);
        gh <= 1'h0;
        $display("override sync test done");
        wb(`OFS_EVENT_STATUS, 1, 7);
        restart(16'h0000);
        ev(1, 0, 1);
        wb(`OFS_EVENT_MASK, 1, 0);
        repeat (2) @(posedge clk_i);
        check(irq, 0);
        wb(`OFS_EVENT_MASK, 1, 1);
        repeat (2) @(posedge clk_i);
        check(irq, 1);
        $display("interrupt mask test done");
        complete_run();
    end
endmodule
`default_nettype wire
